// File: rcc_pkg.sv
/*
 Constants for the reset sequencer and reference chop control.
 Assumes a 25 MHz core clock, a 32 kHz tick input and a mux-cycle start strobe.
*/
// Overview of operation
// R1: Reset pin low or power fault holds all digital logic halted.
// R2: During reset clocks keep running; all control bits are cleared.
// R3: Stay in reset until 4100 RTC ticks after reset pin rises; wake rises.
// R4: On timer expiry the processor starts preboot then boot from address 00.
// R5: At power-up the timer starts once power fault clears; release after 4100.
// R6: Preboot phase lasts exactly 32 processor cycles before primary boot.
// R7: Battery keeps RTC, oscillator, external RAM and watchdog flag retained.
// R8: Firmware control bits shut down engine, converter, test clock, monitor, boost.
// R9: Flash fast read select shortens flash read pulse to 33 ns.
// R10: Emulator clock disable stops emulator clock, blocking emulation access.
// R11: Writing 4, 5 or 6 to trim select picks fuse value read from readback.
// R12: Compensation source 0: engine computes gain correction from coefficients.
// R13: Compensation source 15: engine applies processor-written gain correction.
// R14: Chop code 00 and 11 toggle, 01 positive, 10 reversed.
// R15: Automatic chop inverts the polarity signal once per mux cycle.
// R16: Chop signal high swaps amplifier inputs; low keeps normal orientation.
// R17: Chop code written mid-cycle takes effect only from next mux cycle.
// R18: Alternate mux request inserts one alternate cycle between regular ones.
// R19: Alternate mux cycles run with positive connection under automatic chop.
// R20: Firmware alternates forced polarities after transfer done, then restores 11.
// R21: Firmware inserts one alternate mux cycle per accumulation period.
// R22: Processor waits for transfer done before reading engine output.
// R23: Interrupts fire on falling edges of engine busy and transfer busy.
// R24: Reset condition during counting restarts the timer from zero.
package rcc_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    localparam logic [15:0] GAIN_CORR_OFS = 16'h002e;
    localparam logic [15:0] COMP_SRC_OFS = 16'h0038;
    localparam logic [15:0] TRIM_SEL_OFS = 16'h20fd;
    localparam logic [15:0] TRIM_READ_OFS = 16'h20ff;
    localparam logic [15:0] CTRL_OFS = 16'h2100;
    localparam logic [15:0] STATUS_OFS = 16'h2101;
    // Control register field positions
    localparam int unsigned CTL_ENGINE_EN = 0;
    localparam int unsigned CTL_CONV_DIS = 1;
    localparam int unsigned CTL_CKOUT_DIS = 2;
    localparam int unsigned CTL_REALTIME_MONITOR_ENABLE = 3;
    localparam int unsigned CTL_BOOST_EN = 4;
    localparam int unsigned CTL_FLASH_FAST = 5;
    localparam int unsigned CTL_EMULATOR_CLOCK_DISABLE = 6;
    localparam int unsigned CTL_ALT_MUX = 7;
    localparam int unsigned CTL_CHOP_LO = 8;
    localparam int unsigned CTL_WATCHDOG_OVERFLOW_FLAG = 10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] TRIM_SEL_SLOPE = 8'h04;
    localparam logic [7:0] TRIM_SEL_BGA = 8'h05;
    localparam logic [7:0] TRIM_SEL_BGB = 8'h06;
    localparam logic [31:0] COMP_SRC_INTERNAL = 32'h0000_0000;
    localparam logic [31:0] COMP_SRC_EXTERNAL = 32'h0000_000f;
    localparam logic [1:0] CHOP_AUTO0 = 2'h0;
    localparam logic [1:0] CHOP_POS = 2'h1;
    localparam logic [1:0] CHOP_REV = 2'h2;
    localparam logic [1:0] CHOP_AUTO1 = 2'h3;
    localparam int unsigned RESET_TICKS = 4100;
    localparam int unsigned PREBOOT_CYCLES = 32;
    localparam logic [15:0] BOOT_ADDR = 16'h0000;
    localparam real CORE_CLK_MHZ = 25.0;
    localparam real FLASH_FAST_NS = 33.0;
    localparam real FLASH_SLOW_NS = 66.0;
    // Least pulse times round up
    localparam int unsigned FLASH_FAST_CYC =
        (int'($ceil(FLASH_FAST_NS * CORE_CLK_MHZ / 1000.0)) < 1) ? 1 :
        int'($ceil(FLASH_FAST_NS * CORE_CLK_MHZ / 1000.0));
    localparam int unsigned FLASH_SLOW_CYC =
        (int'($ceil(FLASH_SLOW_NS * CORE_CLK_MHZ / 1000.0)) < 1) ? 1 :
        int'($ceil(FLASH_SLOW_NS * CORE_CLK_MHZ / 1000.0));
    typedef enum logic [1:0] {RCC_RESET, RCC_TIMING, RCC_PREBOOT, RCC_RUN} rcc_state_e;
endpackage

// File: rcc_top.sv
/*
 Reset sequencer, power-save gating, trim readback, temperature-compensation
 select and reference chop control.
 Assumes external_reset_pin_n and power_fault_ok are synchronous to core_clk,
 rtc_tick is a one-cycle pulse per 32 kHz cycle, and mux_cycle_start pulses
 once at each multiplexer cycle boundary.
*/
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module rcc_top
    import rcc_pkg::*;
#(
    parameter int unsigned RESET_TICKS_P = rcc_pkg::RESET_TICKS,
    parameter logic [7:0] FUSE_SLOPE_TRIM = 8'h00,
    parameter logic [7:0] FUSE_BANDGAP_TRIM_A = 8'h00,
    parameter logic [7:0] FUSE_BANDGAP_TRIM_B = 8'h00
)(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic external_reset_pin_n,
    input wire logic power_fault_ok,
    input wire logic rtc_tick,
    input wire logic mux_cycle_start,
    input wire logic engine_busy,
    input wire logic transfer_busy,
    input wire logic watchdog_overflow_set,
    input wire logic [31:0] engine_gain_result,
    input wire logic [rcc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rcc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rcc_pkg::DATA_W-1:0] reg_rdata,
    output logic digital_halt,
    output logic wake,
    output logic processor_run,
    output logic preboot_active,
    output logic [rcc_pkg::ADDR_W-1:0] boot_fetch_addr,
    output logic engine_enable,
    output logic converter_disable,
    output logic test_clock_out_disable,
    output logic realtime_monitor_enable,
    output logic display_boost_enable,
    output logic flash_fast_read_select,
    output logic [7:0] flash_read_pulse_cycles,
    output logic emulator_clock_disable,
    output logic watchdog_overflow_flag,
    output logic gain_from_engine,
    output logic [31:0] gain_correction_word,
    output logic alternate_mux_cycle,
    output logic chop_swap,
    output logic engine_done_irq,
    output logic transfer_done_irq
);
    import rcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset sequencing
    rcc_state_e state;
    rcc_state_e next_state;
    logic [12:0] tick_cnt;
    logic [12:0] next_tick_cnt;
    logic [5:0] pre_cnt;
    logic [5:0] next_pre_cnt;
    logic reset_cond;

    assign reset_cond = !external_reset_pin_n || !power_fault_ok; // [R1]

    always_comb
    begin
        next_state = state;
        next_tick_cnt = tick_cnt;
        next_pre_cnt = pre_cnt;
        if (reset_cond)
        begin
            // Timer restarts from zero on any renewed reset condition
            next_state = RCC_RESET; // [R24]
            next_tick_cnt = 13'h0000;
            next_pre_cnt = 6'h00;
        end
        else
        begin
            case (state)
                RCC_RESET:
                begin
                    next_state = RCC_TIMING; // [R5]
                    next_tick_cnt = 13'h0000;
                end
                RCC_TIMING:
                begin
                    if (rtc_tick)
                    begin
                        if (tick_cnt == 13'(RESET_TICKS_P - 1))
                        begin
                            next_state = RCC_PREBOOT; // [R3]
                            next_pre_cnt = 6'h00;
                        end
                        else
                        begin
                            next_tick_cnt = tick_cnt + 13'h0001;
                        end
                    end
                end
                RCC_PREBOOT:
                begin
                    if (pre_cnt == 6'(PREBOOT_CYCLES - 1))
                    begin
                        next_state = RCC_RUN; // [R6]
                    end
                    else
                    begin
                        next_pre_cnt = pre_cnt + 6'h01;
                    end
                end
                RCC_RUN:
                begin
                    next_state = RCC_RUN;
                end
                default:
                begin
                    next_state = RCC_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state <= RCC_RESET;
            tick_cnt <= 13'h0000;
            pre_cnt <= 6'h00;
        end
        else
        begin
            state <= next_state;
            tick_cnt <= next_tick_cnt;
            pre_cnt <= next_pre_cnt;
        end
    end

    // Halt covers the whole reset timer window, not only the pin low time
    assign digital_halt = (state == RCC_RESET) || (state == RCC_TIMING); // [R1]
    assign wake = !digital_halt; // [R3]
    assign processor_run = wake; // [R4]
    assign preboot_active = (state == RCC_PREBOOT); // [R6]
    assign boot_fetch_addr = BOOT_ADDR; // [R4]

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [7:0] trim_sel;
    logic [7:0] next_trim_sel;
    logic [31:0] comp_src;
    logic [31:0] next_comp_src;
    logic [31:0] gain_wr;
    logic [31:0] next_gain_wr;
    logic [1:0] chop_code;
    logic wd_flag;
    logic next_wd_flag;
    logic [31:0] next_rdata;

    function automatic logic [7:0] trim_value(input logic [7:0] sel);
        case (sel)
            TRIM_SEL_SLOPE: trim_value = {5'h00, FUSE_SLOPE_TRIM[2:0]};
            TRIM_SEL_BGA: trim_value = FUSE_BANDGAP_TRIM_A;
            TRIM_SEL_BGB: trim_value = FUSE_BANDGAP_TRIM_B;
            default: trim_value = 8'h00;
        endcase
    endfunction

    always_comb
    begin
        next_ctrl = ctrl;
        next_trim_sel = trim_sel;
        next_comp_src = comp_src;
        next_gain_wr = gain_wr;
        next_wd_flag = wd_flag;
        next_rdata = 32'h0000_0000;
        if (reg_wr && !digital_halt)
        begin
            case (reg_addr)
                CTRL_OFS: next_ctrl = reg_wdata; // [R8]
                TRIM_SEL_OFS: next_trim_sel = reg_wdata[7:0]; // [R11]
                COMP_SRC_OFS: next_comp_src = reg_wdata;
                GAIN_CORR_OFS: next_gain_wr = reg_wdata; // [R13]
                STATUS_OFS: next_wd_flag = wd_flag & ~reg_wdata[CTL_WATCHDOG_OVERFLOW_FLAG];
                default: next_ctrl = ctrl;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle
        if (watchdog_overflow_set)
        begin
            next_wd_flag = 1'b1;
        end
        if (reg_rd && !digital_halt)
        begin
            case (reg_addr)
                CTRL_OFS: next_rdata = ctrl;
                TRIM_SEL_OFS: next_rdata = {24'h000000, trim_sel};
                TRIM_READ_OFS: next_rdata = {24'h000000, trim_value(trim_sel)}; // [R11]
                COMP_SRC_OFS: next_rdata = comp_src;
                GAIN_CORR_OFS: next_rdata = gain_correction_word; // [R12]
                STATUS_OFS: next_rdata = {23'h0, wd_flag, chop_code, chop_swap,
                    alternate_mux_cycle, preboot_active, processor_run, wake, digital_halt};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn || digital_halt)
        begin
            // Control space clears in reset; clocks run outside this block
            ctrl <= CTRL_RESET; // [R2]
            trim_sel <= 8'h00;
            comp_src <= COMP_SRC_INTERNAL;
            gain_wr <= 32'h0000_0000;
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            ctrl <= next_ctrl;
            trim_sel <= next_trim_sel;
            comp_src <= next_comp_src;
            gain_wr <= next_gain_wr;
            reg_rdata <= next_rdata;
        end
    end

    // Battery-backed flag survives power fault and pin reset
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            wd_flag <= 1'b0;
        end
        else
        begin
            wd_flag <= next_wd_flag; // [R7]
        end
    end

    assign watchdog_overflow_flag = wd_flag; // [R7]
    assign engine_enable = ctrl[CTL_ENGINE_EN]; // [R8]
    assign converter_disable = ctrl[CTL_CONV_DIS]; // [R8]
    assign test_clock_out_disable = ctrl[CTL_CKOUT_DIS]; // [R8]
    assign realtime_monitor_enable = ctrl[CTL_REALTIME_MONITOR_ENABLE]; // [R8]
    assign display_boost_enable = ctrl[CTL_BOOST_EN]; // [R8]
    assign flash_fast_read_select = ctrl[CTL_FLASH_FAST]; // [R9]
    assign flash_read_pulse_cycles = ctrl[CTL_FLASH_FAST] ? 8'(FLASH_FAST_CYC) :
        8'(FLASH_SLOW_CYC); // [R9]
    assign emulator_clock_disable = ctrl[CTL_EMULATOR_CLOCK_DISABLE]; // [R10]
    // Any code other than 15 is treated as internal compensation
    assign gain_from_engine = (comp_src != COMP_SRC_EXTERNAL); // [R12]
    assign gain_correction_word = gain_from_engine ? engine_gain_result : gain_wr; // [R12] [R13]

    ////////////////////////////////////////////////////////////////////////////////
    // Chop control and alternate mux cycles
    logic [1:0] next_chop_code;
    logic auto_pol;
    logic next_auto_pol;
    logic alt_pend;
    logic next_alt_pend;
    logic alt_cyc;
    logic next_alt_cyc;
    logic swap;
    logic next_swap;
    logic eng_busy_d;
    logic transfer_busy_d;

    always_comb
    begin
        next_chop_code = chop_code;
        next_auto_pol = auto_pol;
        next_alt_pend = alt_pend;
        next_alt_cyc = alt_cyc;
        next_swap = swap;
        if (reg_wr && !digital_halt && reg_addr == CTRL_OFS && reg_wdata[CTL_ALT_MUX])
        begin
            next_alt_pend = 1'b1; // [R18]
        end
        if (mux_cycle_start)
        begin
            // Code sampled only at the boundary so polarity is stable all cycle
            next_chop_code = ctrl[CTL_CHOP_LO +: 2]; // [R17]
            next_alt_cyc = alt_pend && !alt_cyc; // [R18]
            if (alt_pend && !alt_cyc)
            begin
                next_alt_pend = 1'b0;
            end
            case (ctrl[CTL_CHOP_LO +: 2]) // [R14]
                CHOP_POS: next_swap = 1'b0;
                CHOP_REV: next_swap = 1'b1;
                default:
                begin
                    if (alt_pend && !alt_cyc)
                    begin
                        next_swap = 1'b0; // [R19]
                    end
                    else
                    begin
                        next_auto_pol = !auto_pol; // [R15]
                        next_swap = !auto_pol;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn || digital_halt)
        begin
            chop_code <= CHOP_AUTO0;
            auto_pol <= 1'b0;
            alt_pend <= 1'b0;
            alt_cyc <= 1'b0;
            swap <= 1'b0;
            eng_busy_d <= 1'b0;
            transfer_busy_d <= 1'b0;
        end
        else
        begin
            chop_code <= next_chop_code;
            auto_pol <= next_auto_pol;
            alt_pend <= next_alt_pend;
            alt_cyc <= next_alt_cyc;
            swap <= next_swap;
            eng_busy_d <= engine_busy;
            transfer_busy_d <= transfer_busy;
        end
    end

    assign chop_swap = swap; // [R16]
    assign alternate_mux_cycle = alt_cyc; // [R18]
    assign engine_done_irq = eng_busy_d && !engine_busy && !digital_halt; // [R23]
    assign transfer_done_irq = transfer_busy_d && !transfer_busy && !digital_halt; // [R23]
endmodule

// File: rcc_top_props.sv
/*
 Checker for the reset sequencer and chop control, bound into rcc_top.
 Assumes only the top ports; one clock core_clk, sync reset resetn.
*/
`timescale 1ns/1ps
module rcc_top_props #(
    parameter int unsigned RESET_TICKS_P = 4100
)(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic external_reset_pin_n,
    input wire logic power_fault_ok,
    input wire logic rtc_tick,
    input wire logic mux_cycle_start,
    input wire logic engine_busy,
    input wire logic [31:0] engine_gain_result,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic digital_halt,
    input wire logic wake,
    input wire logic preboot_active,
    input wire logic flash_fast_read_select,
    input wire logic [7:0] flash_read_pulse_cycles,
    input wire logic gain_from_engine,
    input wire logic [31:0] gain_correction_word,
    input wire logic alternate_mux_cycle,
    input wire logic chop_swap,
    input wire logic engine_done_irq
);
    import rcc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [1:0] ctl_code;
    logic [1:0] cyc_code;
    // Mirror of the chop code in force; forced codes may reverse an alt cycle
    always_ff @(posedge core_clk)
    begin
        if (!resetn || digital_halt)
        begin
            ctl_code <= 2'h0;
            cyc_code <= 2'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == CTRL_OFS)
                ctl_code <= reg_wdata[CTL_CHOP_LO +: 2];
            if (mux_cycle_start)
                cyc_code <= ctl_code;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_halt;
        (!external_reset_pin_n || !power_fault_ok) |=> digital_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("halt missing");
    property p_wake;
        $rose(wake) |-> $past(rtc_tick);
    endproperty
    a_wake: assert property (p_wake) else $error("wake without tick");
    // Exact window: a short preboot would let the emulator in early
    property p_pre;
        $rose(wake) |-> preboot_active ##31 preboot_active ##1 !preboot_active;
    endproperty
    a_pre: assert property (p_pre) else $error("preboot length");
    property p_flash;
        flash_read_pulse_cycles == (flash_fast_read_select ? 8'h01 : 8'h02);
    endproperty
    a_flash: assert property (p_flash) else $error("flash pulse");
    property p_gain;
        gain_from_engine |-> gain_correction_word == engine_gain_result;
    endproperty
    a_gain: assert property (p_gain) else $error("gain source");
    property p_chop;
        !digital_halt && $changed(chop_swap) |-> $past(mux_cycle_start);
    endproperty
    a_chop: assert property (p_chop) else $error("chop mid cycle");
    property p_alt;
        alternate_mux_cycle && (cyc_code[0] == cyc_code[1]) |-> !chop_swap;
    endproperty
    a_alt: assert property (p_alt) else $error("alt cycle reversed");
    property p_irq;
        $fell(engine_busy) && !digital_halt |-> engine_done_irq ##1 !engine_done_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("engine irq");
endmodule
bind rcc_top rcc_top_props #(.RESET_TICKS_P(RESET_TICKS_P)) u_props (.core_clk, .resetn,
    .external_reset_pin_n, .power_fault_ok, .rtc_tick, .mux_cycle_start, .engine_busy,
    .engine_gain_result, .reg_addr, .reg_wdata, .reg_wr,
    .digital_halt, .wake, .preboot_active, .flash_fast_read_select,
    .flash_read_pulse_cycles, .gain_from_engine, .gain_correction_word,
    .alternate_mux_cycle, .chop_swap, .engine_done_irq);

// File: tb_top.sv
/*
 Self-checking bench for rcc_top: boot, registers, chop and interrupts.
 Assumes the checker file is compiled alongside; one 25 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
    import rcc_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, external_reset_pin_n = 1'b1, power_fault_ok = 1'b0;
    logic rtc_tick = 1'b0, mux_cycle_start = 1'b0, engine_busy = 1'b0, transfer_busy = 1'b0;
    logic watchdog_overflow_set = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0, boot_fetch_addr;
    logic [31:0] reg_wdata = 32'h0, engine_gain_result = 32'h0, reg_rdata, gain_correction_word;
    logic digital_halt, wake, processor_run, preboot_active, engine_enable, converter_disable;
    logic test_clock_out_disable, realtime_monitor_enable, display_boost_enable;
    logic flash_fast_read_select, emulator_clock_disable, watchdog_overflow_flag;
    logic gain_from_engine, alternate_mux_cycle, chop_swap, engine_done_irq, transfer_done_irq;
    logic [7:0] flash_read_pulse_cycles;
    int failures = 0;
    int checks_done = 0;
    // Short reset count keeps the boot runs brief
    rcc_top #(.RESET_TICKS_P(4), .FUSE_SLOPE_TRIM(8'hfd), .FUSE_BANDGAP_TRIM_A(8'ha5),
        .FUSE_BANDGAP_TRIM_B(8'h3c)) u_dut (.core_clk, .resetn, .external_reset_pin_n,
        .power_fault_ok, .rtc_tick, .mux_cycle_start, .engine_busy, .transfer_busy,
        .watchdog_overflow_set, .engine_gain_result, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .digital_halt, .wake, .processor_run, .preboot_active,
        .boot_fetch_addr, .engine_enable, .converter_disable, .test_clock_out_disable,
        .realtime_monitor_enable, .display_boost_enable, .flash_fast_read_select,
        .flash_read_pulse_cycles, .emulator_clock_disable, .watchdog_overflow_flag,
        .gain_from_engine, .gain_correction_word, .alternate_mux_cycle, .chop_swap,
        .engine_done_irq, .transfer_done_irq);
    always #20 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask
    // One-cycle strobe: mux start when m is set, else an RTC tick
    task automatic pulse(input bit m);
        @(posedge core_clk);
        {mux_cycle_start, rtc_tick} <= m ? 2'b10 : 2'b01;
        @(posedge core_clk);
        {mux_cycle_start, rtc_tick} <= 2'b00;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic boot(input bit pin, input bit glitch);
        int n;
        @(posedge core_clk);
        external_reset_pin_n <= !pin;
        power_fault_ok <= pin;
        repeat (3) @(posedge core_clk);
        #1 check({wake, digital_halt}, 2'b01);
        pulse(0);
        @(posedge core_clk);
        external_reset_pin_n <= 1'b1;
        power_fault_ok <= 1'b1;
        repeat (2) @(posedge core_clk);
        if (glitch)
        begin
            repeat (3) pulse(0);
            @(posedge core_clk);
            external_reset_pin_n <= 1'b0;
            @(posedge core_clk);
            external_reset_pin_n <= 1'b1;
            repeat (2) @(posedge core_clk);
        end
        repeat (3) pulse(0);
        check(wake, 1'b0);
        pulse(0);
        check({processor_run, wake, digital_halt}, 3'b110);
        check(boot_fetch_addr, 16'h0);
        n = 0;
        while (preboot_active === 1'b1 && n < 99)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        check(n, 32);
    endtask
    task automatic t_ctrl;
        for (int i = 0; i < 7; i++)
        begin
            wr(CTRL_OFS, 32'h1 << i);
            check({emulator_clock_disable, flash_fast_read_select, display_boost_enable,
                realtime_monitor_enable, test_clock_out_disable, converter_disable,
                engine_enable}, 32'h1 << i);
            check(flash_read_pulse_cycles, (i == 5) ? 32'h1 : 32'h2);
            rd(CTRL_OFS, 32'h1 << i);
        end
    endtask
    task automatic t_trim;
        logic [7:0] e[4] = '{8'h05, 8'ha5, 8'h3c, 8'h00};
        for (int i = 0; i < 4; i++)
        begin
            wr(TRIM_SEL_OFS, 32'h4 + i);
            rd(TRIM_SEL_OFS, 32'h4 + i);
            rd(TRIM_READ_OFS, {24'h0, e[i]});
        end
        wr(TRIM_SEL_OFS, 32'h5);
        wr(TRIM_READ_OFS, 32'hff);
        rd(TRIM_READ_OFS, 32'ha5);
        rd(16'h1234, 32'h0);
    endtask
    task automatic t_comp;
        @(posedge core_clk);
        engine_gain_result <= 32'hcafe_0001;
        wr(COMP_SRC_OFS, COMP_SRC_INTERNAL);
        wr(GAIN_CORR_OFS, 32'h1234_5678);
        check(gain_from_engine, 1'b1);
        check(gain_correction_word, 32'hcafe_0001);
        rd(GAIN_CORR_OFS, 32'hcafe_0001);
        wr(COMP_SRC_OFS, COMP_SRC_EXTERNAL);
        check(gain_from_engine, 1'b0);
        check(gain_correction_word, 32'h1234_5678);
        rd(COMP_SRC_OFS, 32'hf);
    endtask
    task automatic t_chop;
        logic [1:0] c[6] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h2, 2'h1};
        logic e[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++)
        begin
            wr(CTRL_OFS, {22'h0, c[i], 8'h0});
            if (i > 0)
                check(chop_swap, e[i - 1]);
            pulse(1);
            check(chop_swap, e[i]);
        end
        wr(CTRL_OFS, {22'h0, CHOP_AUTO1, 8'h80});
        pulse(1);
        check({alternate_mux_cycle, chop_swap}, 2'b10);
        pulse(1);
        check(alternate_mux_cycle, 1'b0);
    endtask
    task automatic t_irq;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge core_clk);
            {transfer_busy, engine_busy} <= i ? 2'b10 : 2'b01;
            repeat (3) @(posedge core_clk);
            {transfer_busy, engine_busy} <= 2'b00;
            #1 check({transfer_done_irq, engine_done_irq}, i ? 2'b10 : 2'b01);
            @(posedge core_clk);
            #1 check({transfer_done_irq, engine_done_irq}, 2'b00);
        end
        rd(GAIN_CORR_OFS, 32'h1234_5678);
    endtask
    task automatic t_wd;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge core_clk);
            watchdog_overflow_set <= 1'b1;
            @(posedge core_clk);
            watchdog_overflow_set <= 1'b0;
            #1 check(watchdog_overflow_flag, 1'b1);
            if (i == 0)
                wr(STATUS_OFS, 32'h400);
            if (i == 0)
                check(watchdog_overflow_flag, 1'b0);
        end
        // Set and clear in one cycle: the set must win
        @(posedge core_clk);
        {watchdog_overflow_set, reg_wr} <= 2'b11;
        reg_addr <= STATUS_OFS;
        reg_wdata <= 32'h400;
        @(posedge core_clk);
        {watchdog_overflow_set, reg_wr} <= 2'b00;
        #1 check(watchdog_overflow_flag, 1'b1);
        rd(STATUS_OFS, 32'h1c6);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        boot(1'b0, 1'b0);
        t_ctrl();
        t_trim();
        t_comp();
        t_chop();
        t_irq();
        t_wd();
        wr(CTRL_OFS, 32'h3f);
        boot(1'b1, 1'b1);
        check({watchdog_overflow_flag, engine_enable}, 2'b10);
        rd(CTRL_OFS, 32'h0);
        rd(TRIM_SEL_OFS, 32'h0);
        test_done();
    end
    // Whole run is under a thousand cycles; this only catches a hang
    initial
    begin
        #(40 * 5000);
        failures++;
        test_done();
    end
endmodule
